// ==== design/usb_bulk_double_buffer.sv ====
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/100ps
module usb_bulk_double_buffer (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [usb_dblbuf_pkg::ADDR_W-1:0] addr_i,
  input wire logic [usb_dblbuf_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic token_i,
  input wire logic token_in_i,
  input wire logic xact_ok_i,
  input wire logic xact_fail_i,
  input wire logic [usb_dblbuf_pkg::DATA_W-1:0] rx_count_i,
  output logic [usb_dblbuf_pkg::DATA_W-1:0] rdata_o,
  output logic answer_valid_o,
  output logic [1:0] answer_status_o,
  output logic buf_sel_o,
  output logic [usb_dblbuf_pkg::DATA_W-1:0] buf_ptr_o,
  output logic [usb_dblbuf_pkg::DATA_W-1:0] buf_len_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic rx_done_reg;
  logic tx_done_reg;
  logic rx_tog_reg;
  logic tx_tog_reg;
  logic [1:0] stat_rx_reg;
  logic [1:0] stat_tx_reg;
  logic [1:0] type_reg;
  logic kind_reg;
  logic dbl_active_reg;
  logic pending_reg;
  logic pend_in_reg;
  logic pend_buf_reg;
  logic [usb_dblbuf_pkg::IRQ_W-1:0] irq_status_reg;
  logic [usb_dblbuf_pkg::IRQ_W-1:0] irq_status_next;
  logic [usb_dblbuf_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [usb_dblbuf_pkg::IRQ_W-1:0] irq_mask_next;
  logic [usb_dblbuf_pkg::DATA_W-1:0] desc_mem [4];

  logic wr_ep;
  logic dbl_cfg;
  logic dev_buf;
  logic conflict;
  logic [1:0] tok_stat;
  logic [1:0] eff_stat;
  logic done_ok;
  logic done_fail;
  logic [usb_dblbuf_pkg::IRQ_W-1:0] irq_events;
  logic [usb_dblbuf_pkg::DATA_W-1:0] ep_word;

  ////////////////////////////////////////////////////////////////////////////
  // decoding

  function automatic logic [1:0] effective_status(
    input logic [1:0] stat,
    input logic masking,
    input logic clash
  );
    // only a valid pair is masked; anything else programmed wins
    if (stat == usb_dblbuf_pkg::STAT_VALID && masking && clash)
    begin
      return usb_dblbuf_pkg::STAT_NAK;
    end
    return stat;
  endfunction : effective_status

  function automatic logic is_desc(input logic [2:0] a);
    return a >= usb_dblbuf_pkg::OFS_DESC_BASE
      && a <= usb_dblbuf_pkg::OFS_DESC_LAST;
  endfunction : is_desc

  assign wr_ep = wr_i && addr_i == usb_dblbuf_pkg::OFS_ENDPOINT;
  // bulk type plus kind bit set
  assign dbl_cfg = kind_reg && type_reg == usb_dblbuf_pkg::TYPE_BULK;
  // each token direction is gated by its own pair, so an unused pair
  // left disabled answers with the disabled status
  assign tok_stat = token_in_i ? stat_tx_reg : stat_rx_reg;
  assign eff_stat = effective_status(tok_stat, dbl_active_reg, conflict);
  assign done_ok = xact_ok_i && pending_reg;
  assign done_fail = xact_fail_i && pending_reg;

  buffer_select u_buffer_select (
    .dbl_i(dbl_cfg),
    .token_in_i(token_in_i),
    .rx_tog_i(rx_tog_reg),
    .tx_tog_i(tx_tog_reg),
    .dev_buf_o(dev_buf),
    .conflict_o(conflict)
  );

  ////////////////////////////////////////////////////////////////////////////
  // token answer and transaction tracking

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      answer_valid_o <= 1'b0;
      answer_status_o <= usb_dblbuf_pkg::STAT_DISABLED;
      buf_sel_o <= 1'b0;
      buf_ptr_o <= usb_dblbuf_pkg::WORD_ZERO;
      buf_len_o <= usb_dblbuf_pkg::WORD_ZERO;
    end
    else
    begin
      answer_valid_o <= token_i;
      if (token_i)
      begin
        answer_status_o <= eff_stat;
        buf_sel_o <= dev_buf;
        buf_ptr_o <= desc_mem[{dev_buf, 1'b0}];
        buf_len_o <= desc_mem[{dev_buf, 1'b1}];
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      pending_reg <= 1'b0;
      pend_in_reg <= 1'b0;
      pend_buf_reg <= 1'b0;
    end
    else if (token_i)
    begin
      // only a transaction we accepted can complete
      pending_reg <= eff_stat == usb_dblbuf_pkg::STAT_VALID;
      pend_in_reg <= token_in_i;
      pend_buf_reg <= dev_buf;
    end
    else if (xact_ok_i || xact_fail_i)
    begin
      pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      dbl_active_reg <= 1'b0;
    end
    else if (!dbl_cfg)
    begin
      dbl_active_reg <= 1'b0;
    end
    else if (done_ok)
    begin
      dbl_active_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // endpoint_control_register

  // completion flags: hardware set beats a software clear (write 0)
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      rx_done_reg <= 1'b0;
      tx_done_reg <= 1'b0;
    end
    else
    begin
      if (done_ok && !pend_in_reg)
      begin
        rx_done_reg <= 1'b1;
      end
      else if (wr_ep && !wdata_i[usb_dblbuf_pkg::RX_DONE_BIT])
      begin
        rx_done_reg <= 1'b0;
      end
      if (done_ok && pend_in_reg)
      begin
        tx_done_reg <= 1'b1;
      end
      else if (wr_ep && !wdata_i[usb_dblbuf_pkg::TX_DONE_BIT])
      begin
        tx_done_reg <= 1'b0;
      end
    end
  end

  // toggles change only by toggling, so software and hardware
  // toggles in one cycle both take effect
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      rx_tog_reg <= 1'b0;
      tx_tog_reg <= 1'b0;
    end
    else
    begin
      rx_tog_reg <= rx_tog_reg
        ^ (wr_ep && wdata_i[usb_dblbuf_pkg::RX_TOG_BIT])
        ^ (done_ok && !pend_in_reg);
      tx_tog_reg <= tx_tog_reg
        ^ (wr_ep && wdata_i[usb_dblbuf_pkg::TX_TOG_BIT])
        ^ (done_ok && pend_in_reg);
    end
  end

  // a failed transaction never reaches these updates
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      stat_rx_reg <= usb_dblbuf_pkg::STAT_DISABLED;
      stat_tx_reg <= usb_dblbuf_pkg::STAT_DISABLED;
    end
    else if (wr_ep)
    begin
      stat_rx_reg <= wdata_i[usb_dblbuf_pkg::STAT_RX_LSB +: 2];
      stat_tx_reg <= wdata_i[usb_dblbuf_pkg::STAT_TX_LSB +: 2];
    end
    else if (done_ok && !dbl_active_reg)
    begin
      // ordinary flow control, also on the completion that enters double buffering; after that the pair keeps its status
      if (pend_in_reg)
      begin
        stat_tx_reg <= usb_dblbuf_pkg::STAT_NAK;
      end
      else
      begin
        stat_rx_reg <= usb_dblbuf_pkg::STAT_NAK;
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      type_reg <= usb_dblbuf_pkg::TYPE_BULK;
      kind_reg <= 1'b0;
    end
    else if (wr_ep)
    begin
      type_reg <= wdata_i[usb_dblbuf_pkg::TYPE_LSB +: 2];
      kind_reg <= wdata_i[usb_dblbuf_pkg::KIND_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // descriptor entries

  // count write-back on success of a reception only; it beats a
  // software write to the same cycle
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < 4; i++)
      begin
        desc_mem[i] <= usb_dblbuf_pkg::WORD_ZERO;
      end
    end
    else if (done_ok && !pend_in_reg)
    begin
      desc_mem[{pend_buf_reg, 1'b1}] <= rx_count_i;
    end
    else if (wr_i && is_desc(addr_i))
    begin
      desc_mem[2'(addr_i - usb_dblbuf_pkg::OFS_DESC_BASE)] <= wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts

  always_comb
  begin
    irq_events = usb_dblbuf_pkg::IRQ_RESET;
    irq_events[usb_dblbuf_pkg::IRQ_RX_DONE] = done_ok && !pend_in_reg;
    irq_events[usb_dblbuf_pkg::IRQ_TX_DONE] = done_ok && pend_in_reg;
    irq_events[usb_dblbuf_pkg::IRQ_NAK_SENT] = token_i
      && eff_stat == usb_dblbuf_pkg::STAT_NAK;
    irq_events[usb_dblbuf_pkg::IRQ_FAILED] = done_fail;
    irq_status_next = irq_status_reg;
    if (rd_i && addr_i == usb_dblbuf_pkg::OFS_IRQ_STATUS)
    begin
      irq_status_next = usb_dblbuf_pkg::IRQ_RESET;
    end
    // an event in the clearing read's cycle survives
    irq_status_next = irq_status_next | irq_events;
    irq_mask_next = irq_mask_reg;
    if (wr_i && addr_i == usb_dblbuf_pkg::OFS_IRQ_MASK)
    begin
      irq_mask_next = wdata_i[usb_dblbuf_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      irq_status_reg <= usb_dblbuf_pkg::IRQ_RESET;
      irq_mask_reg <= usb_dblbuf_pkg::IRQ_RESET;
      irq_o <= 1'b0;
    end
    else
    begin
      irq_status_reg <= irq_status_next;
      irq_mask_reg <= irq_mask_next;
      // from next values so the output tracks the status without lag
      irq_o <= |(irq_status_next & irq_mask_next);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port

  always_comb
  begin
    ep_word = usb_dblbuf_pkg::WORD_ZERO;
    ep_word[usb_dblbuf_pkg::RX_DONE_BIT] = rx_done_reg;
    ep_word[usb_dblbuf_pkg::RX_TOG_BIT] = rx_tog_reg;
    ep_word[usb_dblbuf_pkg::STAT_RX_LSB +: 2] = stat_rx_reg;
    ep_word[usb_dblbuf_pkg::TYPE_LSB +: 2] = type_reg;
    ep_word[usb_dblbuf_pkg::KIND_BIT] = kind_reg;
    ep_word[usb_dblbuf_pkg::TX_DONE_BIT] = tx_done_reg;
    ep_word[usb_dblbuf_pkg::TX_TOG_BIT] = tx_tog_reg;
    ep_word[usb_dblbuf_pkg::STAT_TX_LSB +: 2] = stat_tx_reg;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || !rd_i)
    begin
      rdata_o <= usb_dblbuf_pkg::WORD_ZERO;
    end
    else if (addr_i == usb_dblbuf_pkg::OFS_ENDPOINT)
    begin
      rdata_o <= ep_word;
    end
    else if (addr_i == usb_dblbuf_pkg::OFS_IRQ_STATUS)
    begin
      rdata_o <= {12'h000, irq_status_reg};
    end
    else if (addr_i == usb_dblbuf_pkg::OFS_IRQ_MASK)
    begin
      rdata_o <= {12'h000, irq_mask_reg};
    end
    else if (is_desc(addr_i))
    begin
      rdata_o <= desc_mem[2'(addr_i - usb_dblbuf_pkg::OFS_DESC_BASE)];
    end
    else
    begin
      rdata_o <= usb_dblbuf_pkg::WORD_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  AST_CONFLICT_NAK: assert property (
    token_i && dbl_active_reg && conflict
      && tok_stat == usb_dblbuf_pkg::STAT_VALID
    |=> answer_valid_o && answer_status_o == usb_dblbuf_pkg::STAT_NAK)
    else $error("conflict not answered with NAK");

  AST_OUT_NAK: assert property (
    token_i && !token_in_i && eff_stat == usb_dblbuf_pkg::STAT_NAK
    |=> answer_status_o == usb_dblbuf_pkg::STAT_NAK && !pending_reg)
    else $error("OUT accepted while receive status is NAK");

  AST_OVERRIDE: assert property (
    token_i && tok_stat != usb_dblbuf_pkg::STAT_VALID
    |=> answer_status_o == $past(tok_stat))
    else $error("programmed status not honoured");

  AST_BUF_FROM_TOGGLE: assert property (
    token_i && dbl_cfg
    |=> buf_sel_o == ($past(token_in_i) ? $past(tx_tog_reg)
      : $past(rx_tog_reg)))
    else $error("buffer not taken from device toggle");

  AST_DONE_AND_TOGGLE: assert property (
    done_ok && !pend_in_reg && !wr_ep
    |=> rx_done_reg && rx_tog_reg != $past(rx_tog_reg))
    else $error("receive completion not recorded");

  AST_KEEP_VALID: assert property (
    done_ok && dbl_active_reg && !wr_ep
    |=> $stable(stat_rx_reg) && $stable(stat_tx_reg))
    else $error("status changed in double-buffered mode");

  AST_FAIL_SILENT: assert property (
    xact_fail_i && !wr_i
    |=> $stable(rx_tog_reg) && $stable(tx_tog_reg)
      && $stable(stat_rx_reg) && $stable(stat_tx_reg)
      && $stable(desc_mem[3]) && $stable(desc_mem[1]))
    else $error("failed transaction changed state");

  AST_ENTER: assert property (
    done_ok && dbl_cfg && !wr_ep |=> dbl_active_reg)
    else $error("double-buffered flow control not entered");

  AST_REVERT_NAK: assert property (
    done_ok && !dbl_active_reg && pend_in_reg && !wr_ep
    |=> stat_tx_reg == usb_dblbuf_pkg::STAT_NAK ##1 !dbl_active_reg
      || dbl_cfg)
    else $error("ordinary completion did not set NAK");

  COV_DBL_SWAP: cover property (
    done_ok && dbl_active_reg ##[1:20] done_ok && dbl_active_reg);
  COV_CONFLICT: cover property (
    token_i && dbl_active_reg && conflict);
  COV_FAIL: cover property (done_fail);

endmodule : usb_bulk_double_buffer

// ==== design/usb_dblbuf_pkg.sv ====
package usb_dblbuf_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 3;
  // register word indices
  localparam logic [2:0] OFS_ENDPOINT = 3'h0;
  localparam logic [2:0] OFS_IRQ_STATUS = 3'h1;
  localparam logic [2:0] OFS_IRQ_MASK = 3'h2;
  localparam logic [2:0] OFS_DESC_BASE = 3'h3;
  localparam logic [2:0] OFS_DESC_LAST = 3'h6;
  // endpoint_control_register fields
  localparam int RX_DONE_BIT = 15;
  localparam int RX_TOG_BIT = 14;
  localparam int STAT_RX_LSB = 12;
  localparam int TYPE_LSB = 9;
  localparam int KIND_BIT = 8;
  localparam int TX_DONE_BIT = 7;
  localparam int TX_TOG_BIT = 6;
  localparam int STAT_TX_LSB = 4;
  typedef enum logic [1:0] {
    STAT_DISABLED = 2'h0,
    STAT_STALL = 2'h1,
    STAT_NAK = 2'h2,
    STAT_VALID = 2'h3
  } ep_status_type;
  localparam logic [1:0] TYPE_BULK = 2'h0;
  // interrupt status bits
  localparam int IRQ_W = 4;
  localparam int IRQ_RX_DONE = 0;
  localparam int IRQ_TX_DONE = 1;
  localparam int IRQ_NAK_SENT = 2;
  localparam int IRQ_FAILED = 3;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
  localparam logic [DATA_W-1:0] WORD_ZERO = 16'h0000;
endpackage : usb_dblbuf_pkg

// ==== design/buffer_select.sv ====
`timescale 1ns/100ps
module buffer_select (
  input wire logic dbl_i,
  input wire logic token_in_i,
  input wire logic rx_tog_i,
  input wire logic tx_tog_i,
  output logic dev_buf_o,
  output logic conflict_o
);
  logic software_buffer_flag;

  always_comb
  begin
    if (dbl_i)
    begin
      dev_buf_o = token_in_i ? tx_tog_i : rx_tog_i;
      software_buffer_flag = token_in_i ? rx_tog_i : tx_tog_i;
      conflict_o = (dev_buf_o == software_buffer_flag);
    end
    else
    begin
      // single buffering: IN uses transmit entries, OUT receive entries
      dev_buf_o = ~token_in_i;
      software_buffer_flag = token_in_i;
      conflict_o = 1'b0;
    end
  end
endmodule : buffer_select

// ==== tb/usb_host_model.sv ====
`timescale 1ns/100ps
module usb_host_model (
  input wire logic sys_clk_i,
  input wire logic answer_valid_o,
  input wire logic [1:0] answer_status_o,
  output logic token_i,
  output logic token_in_i,
  output logic xact_ok_i,
  output logic xact_fail_i,
  output logic [15:0] rx_count_i
);
  logic [15:0] cnt_reg = 16'h0000;
  logic [15:0] junk_reg = 16'hA5C3;
  initial
  begin
    token_i = 1'b0;
    token_in_i = 1'b0;
    xact_ok_i = 1'b0;
    xact_fail_i = 1'b0;
  end
  // count lines carry junk outside the completion pulse
  always @(posedge sys_clk_i)
    junk_reg <= {junk_reg[14:0], ~junk_reg[15]};
  assign rx_count_i = xact_ok_i ? cnt_reg : junk_reg;
  ////////////////////////////////////////////////////////////////////////
  task automatic xact(input logic dir, input logic fl,
    input logic [15:0] n, output logic v, output logic [1:0] st);
    @(posedge sys_clk_i);
    token_i <= 1'b1;
    token_in_i <= dir;
    @(posedge sys_clk_i);
    token_i <= 1'b0;
    #1;
    v = answer_valid_o;
    st = answer_status_o;
    // no data stage unless accepted; a NAKed host simply retries later
    if (st == 2'h3)
    begin
      repeat (2) @(posedge sys_clk_i);
      cnt_reg <= n;
      xact_ok_i <= !fl;
      xact_fail_i <= fl;
      @(posedge sys_clk_i);
      xact_ok_i <= 1'b0;
      xact_fail_i <= 1'b0;
      #1;
    end
  endtask : xact
endmodule : usb_host_model

// ==== tb/tb_usb_bulk_double_buffer.sv ====
`timescale 1ns/100ps
module tb_usb_bulk_double_buffer;
  logic sys_clk_i, rst_i, wr_i, rd_i, token_i, token_in_i;
  logic xact_ok_i, xact_fail_i, answer_valid_o, buf_sel_o, irq_o;
  logic [2:0] addr_i;
  logic [1:0] answer_status_o;
  logic [15:0] wdata_i, rx_count_i, rdata_o, buf_ptr_o, buf_len_o, tmp;
  logic [15:0] d [0:7];
  logic [31:0] seed = 32'h7FBBF730;
  int fail_count = 0;
  int check_count = 0;
  usb_bulk_double_buffer DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .token_i(token_i), .token_in_i(token_in_i), .xact_ok_i(xact_ok_i),
    .xact_fail_i(xact_fail_i), .rx_count_i(rx_count_i), .rdata_o(rdata_o),
    .answer_valid_o(answer_valid_o), .answer_status_o(answer_status_o),
    .buf_sel_o(buf_sel_o), .buf_ptr_o(buf_ptr_o), .buf_len_o(buf_len_o),
    .irq_o(irq_o));
  usb_host_model host (.sys_clk_i(sys_clk_i),
    .answer_valid_o(answer_valid_o), .answer_status_o(answer_status_o),
    .token_i(token_i), .token_in_i(token_in_i), .xact_ok_i(xact_ok_i),
    .xact_fail_i(xact_fail_i), .rx_count_i(rx_count_i));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction : rnd
  function automatic logic [15:0] ep(input logic rxd, rxt,
    input logic [1:0] rxs, input logic k, txd, txt, input logic [1:0] txs);
    return {rxd, rxt, rxs, 3'h0, k, txd, txt, txs, 4'h0};
  endfunction : ep
  task automatic chk(input logic [15:0] got, input logic [15:0] e);
    check_count++;
    if (got !== e)
      $display("BAD t=%0t got %h want %h", $time, got, e);
    if (got !== e)
      fail_count++;
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [15:0] v);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, e);
  endtask : rd
  // call right after rd: read data must have dropped back to zero
  task automatic ck_irq(input logic e);
    @(posedge sys_clk_i);
    #1;
    chk(rdata_o, 16'h0000);
    chk({15'h0000, irq_o}, {15'h0000, e});
  endtask : ck_irq
  task automatic xo(input logic dir, fl, input logic [15:0] n,
    input logic [1:0] es, input logic sel, input logic [2:0] pi);
    logic v;
    logic [1:0] st;
    host.xact(dir, fl, n, v, st);
    chk({15'h0000, v}, 16'h0001);
    chk({14'h0000, st}, {14'h0000, es});
    if (es == 2'h3)
    begin
      chk({15'h0000, buf_sel_o}, {15'h0000, sel});
      chk(buf_ptr_o, d[pi]);
      chk(buf_len_o, d[pi + 3'h1]);
    end
  endtask : xo
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  initial
  begin
    rst_i = 1'b1;
    addr_i = 3'h0;
    wdata_i = 16'h0000;
    wr_i = 1'b0;
    rd_i = 1'b0;
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    #1;
    chk({13'h0000, irq_o, answer_valid_o, buf_sel_o}, 16'h0000);
    rd(usb_dblbuf_pkg::OFS_ENDPOINT, 16'h0000);
    wr(3'h7, rnd());
    rd(3'h7, 16'h0000);
    for (int i = 3; i < 7; i++)
    begin
      d[i] = rnd();
      wr(i[2:0], d[i]);
      rd(i[2:0], d[i]);
    end
    wr(usb_dblbuf_pkg::OFS_IRQ_MASK, 16'h000F);
    // receive-only double buffer; software flag set to the other buffer
    wr(3'h0, ep(0, 0, 3, 1, 0, 1, 0));
    rd(3'h0, ep(0, 0, 3, 1, 0, 1, 0));
    xo(0, 0, 16'h0000, 3, 0, 3'h3);
    d[4] = 16'h0000;
    rd(3'h0, ep(1, 1, 2, 1, 0, 1, 0));
    rd(3'h4, d[4]);
    ck_irq(1'b1);
    rd(usb_dblbuf_pkg::OFS_IRQ_STATUS, 16'h0001);
    ck_irq(1'b0);
    wr(3'h0, ep(0, 0, 3, 1, 0, 0, 0));
    xo(0, 0, 16'h0000, 2, 0, 3'h3);
    rd(3'h0, ep(0, 1, 3, 1, 0, 1, 0));
    rd(3'h1, 16'h0004);
    wr(3'h0, ep(0, 0, 3, 1, 0, 1, 0));
    tmp = rnd();
    xo(0, 0, tmp, 3, 1, 3'h5);
    d[6] = tmp;
    rd(3'h0, ep(1, 0, 3, 1, 0, 0, 0));
    rd(3'h6, d[6]);
    rd(3'h1, 16'h0001);
    wr(3'h0, ep(0, 0, 3, 1, 0, 1, 0));
    xo(0, 1, rnd(), 3, 0, 3'h3);
    rd(3'h0, ep(0, 0, 3, 1, 0, 1, 0));
    rd(3'h4, d[4]);
    rd(3'h1, 16'h0008);
    // first write equalises both flags, so the override meets a conflict
    for (int s = 0; s < 3; s++)
    begin
      wr(3'h0, ep(0, 0, s[1:0], 1, 0, s == 0, 0));
      xo(0, 0, 16'h0000, s[1:0], 0, 3'h3);
    end
    rd(3'h1, 16'h0004);
    wr(3'h0, ep(0, 0, 3, 0, 0, 1, 0));
    xo(0, 0, 16'hFFFF, 3, 1, 3'h5);
    d[6] = 16'hFFFF;
    rd(3'h0, ep(1, 1, 2, 0, 0, 1, 0));
    rd(3'h6, d[6]);
    rd(3'h1, 16'h0001);
    wr(3'h2, 16'h0001);
    wr(3'h0, ep(0, 0, 0, 0, 0, 0, 3));
    xo(1, 0, rnd(), 3, 0, 3'h3);
    rd(3'h0, ep(0, 1, 0, 0, 1, 0, 2));
    ck_irq(1'b0);
    rd(3'h4, d[4]);
    rd(3'h1, 16'h0002);
    results();
  end
endmodule : tb_usb_bulk_double_buffer
